// ===== dac_input_fifo_latency_sync_tb_top.sv
`timescale 1ns/1ps
module dac_input_fifo_latency_sync_tb_top;
   import dfs_pkg::*;
   logic                aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0]   awaddr, araddr;
   logic [DATA_W-1:0]   wdata, rdata, d;
   logic [1:0]          bresp, rresp, r;
   logic                dclk, frame, sync, dac, send, busy;
   logic [SAMPLE_W-1:0] sdata, word, w, last;
   logic [SAMPLE_W-1:0] mem [8];
   dfs_sample_t         fout;
   int                  n_mismatch, checks, cyc, nval, n0, seed, dep;
   int                  f [2];

   dfs_fifo_sync uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .source_data_clock(dclk), .sample_data(sdata),
      .frame_in(frame), .sync_ref_in(sync), .dac_sample_clock(dac), .filter_out(fout));
   dfs_source_model src (.aclk(aclk), .send(send), .word(word), .dclk(dclk),
      .data(sdata), .busy(busy));

   // clock and watchdog; the ceiling is over thirty times the expected run
   initial aclk = 1'b0;
   always #25 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end
   // count reads handed to the filter
   always @(posedge aclk)
      if (fout.valid === 1'b1)
      begin
         nval++;
         last = fout.data;
      end

   task automatic wrap_up();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // expected status word: read pointer trails write pointer by the depth
   function automatic logic [31:0] stat_exp(input int dp, wp);
      return {21'h0, 3'(wp - dp), 1'b0, 3'(wp), 1'b0, 3'(dp)};
   endfunction
   // each channel released at the edge it is taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_p || w_p)
      begin
         @(posedge aclk);
         aw_p = aw_p && !awready;
         w_p = w_p && !wready;
         awvalid <= aw_p;
         wvalid <= w_p;
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // pins held 4 aclk each way so the samplers accept every change
   task automatic pins(input logic fr, sy, dc);
      @(posedge aclk);
      frame <= fr;
      sync <= sy;
      dac <= dc;
      repeat (4) @(posedge aclk);
      frame <= 1'b0;
      sync <= 1'b0;
      dac <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
   task automatic put(input logic [15:0] v);
      @(posedge aclk);
      word <= v;
      send <= 1'b1;
      @(posedge aclk);
      send <= 1'b0;
      do @(posedge aclk); while (busy);
   endtask

   // main sequence
   initial
   begin
      seed = 55472;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {frame, sync, dac, send, awaddr, araddr, wdata, word} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(12'h384);
      chk("cfg2 reset", d, 32'h0000_0000);
      axi_rd(12'h004);
      chk("ctrl reset", d, 32'h0000_0014);
      axi_rd(12'h008);
      chk("status reset", d, 32'h0000_0000);
      axi_wr(12'h384, 32'h0000_001a);
      chk("cfg2 write resp", 32'(r), 32'(RESP_OKAY));
      axi_rd(12'h384);
      chk("cfg2 value", d, 32'h0000_001a);
      chk("cfg2 read resp", 32'(r), 32'(RESP_OKAY));
      axi_rd(12'h010);
      chk("unmapped", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
      axi_wr(12'h008, 32'h0000_0fff);
      chk("status write resp", 32'(r), 32'(RESP_SLVERR));
      for (int i = 0; i < 3; i++)
      begin
         dep = (i == 0) ? 4 : 1 + $unsigned($random(seed)) % 7;
         axi_wr(12'h004, 32'(dep));
         pins(1'b1, 1'b1, 1'b0);
         axi_rd(12'h008);
         chk("depth after sync", d & 32'h0fff, stat_exp(dep, 0));
         for (int k = 0; k < 12; k++)
         begin
            w = 16'($random(seed));
            put(w);
            mem[k % 8] = w;
            n0 = nval;
            pins(1'b0, 1'b0, 1'b1);
            chk("reads per tick", nval - n0, 1);
            if (k >= dep)
               chk("fifo word", last, mem[(k - dep) % 8]);
         end
         axi_rd(12'h008);
         chk("status after run", d & 32'h0fff, stat_exp(dep, 12));
      end
      axi_wr(12'h004, 32'h0000_0000);
      axi_rd(12'h004);
      chk("zero depth kept", d, 32'(dep));
      for (int p = 0; p < 2; p++)
      begin
         axi_wr(12'h004, 32'h0000_0014 | (p << 5));
         pins(1'b0, 1'b1, 1'b0);
         n0 = nval;
         f[p] = 0;
         for (int t = 1; t <= 4; t++)
         begin
            pins(1'b0, 1'b0, 1'b1);
            if (f[p] == 0 && nval != n0)
               f[p] = t;
         end
         chk("reads in 2x", nval - n0, 2);
      end
      chk("phase gap", (f[0] > f[1]) ? f[0] - f[1] : f[1] - f[0], 1);
      wrap_up();
   end
endmodule

// ===== dfs_fifo_sync.sv
`timescale 1ns/1ps
// Contract
// - eight slot fifo, pointers wrap seven to zero
// - depth is read-to-write pointer distance
// - sample latency in fifo equals depth
// - depth resettable to a predefined value
// - any nonzero reset depth, four typical
// - pointers and divider start arbitrary; here aresetn clears both pointers and loads the divider with RST_DIV_PHASE
// - divider phase unknown unless forced
// - half-rate clock reads fifo in 2x
// - divider phases differ by one dac cycle
// - frame resets write, sync resets read side
// - fifo absorbs constant source offset
module dfs_fifo_sync
   import dfs_pkg::*;
(
   input  wire logic                       aclk,              // system clock, 20 MHz
   input  wire logic                       aresetn,           // sync reset, active low
   input  wire logic [dfs_pkg::ADDR_W-1:0] s_axi_awaddr,      // write address
   input  wire logic                       s_axi_awvalid,     // write address valid
   output logic                            s_axi_awready,     // write address ready
   input  wire logic [dfs_pkg::DATA_W-1:0] s_axi_wdata,       // write data
   input  wire logic [3:0]                 s_axi_wstrb,       // byte enables
   input  wire logic                       s_axi_wvalid,      // write data valid
   output logic                            s_axi_wready,      // write data ready
   output logic [1:0]                      s_axi_bresp,       // write response
   output logic                            s_axi_bvalid,      // write response valid
   input  wire logic                       s_axi_bready,      // write response ready
   input  wire logic [dfs_pkg::ADDR_W-1:0] s_axi_araddr,      // read address
   input  wire logic                       s_axi_arvalid,     // read address valid
   output logic                            s_axi_arready,     // read address ready
   output logic [dfs_pkg::DATA_W-1:0]      s_axi_rdata,       // read data
   output logic [1:0]                      s_axi_rresp,       // read response
   output logic                            s_axi_rvalid,      // read data valid
   input  wire logic                       s_axi_rready,      // read data ready
   input  wire logic                       source_data_clock, // data clock pin from source
   input  wire logic [dfs_pkg::SAMPLE_W-1:0] sample_data,     // sample word pins
   input  wire logic                       frame_in,          // frame reference pin
   input  wire logic                       sync_ref_in,       // sync reference clock pin
   input  wire logic                       dac_sample_clock,  // dac sampling clock pin
   output dfs_pkg::dfs_sample_t            filter_out         // sample to interpolation filter
);
   import dfs_pkg::*;

   // one decoder for both read and write paths
   function automatic dfs_sel_t dfs_decode(input logic [ADDR_W-1:0] addr);
      dfs_sel_t sel;
      sel = SEL_NONE;
      if (addr[1:0] == 2'h0)
      begin
         if (addr[ADDR_W-1:2] == IDX_STARTUP_CFG2)
            sel = SEL_CFG2;
         else if (addr[ADDR_W-1:2] == IDX_FIFO_CTRL)
            sel = SEL_CTRL;
         else if (addr[ADDR_W-1:2] == IDX_FIFO_STATUS)
            sel = SEL_STAT;
      end
      return sel;
   endfunction

   logic [PIN_W-1:0]       meta_q [SYNC_STAGES];
   logic [PIN_W-1:0]       lvl_q;
   logic [PIN_EDGES-1:0]   rise;
   logic                   wr_tick;
   logic                   dac_tick;
   logic                   rd_tick;
   logic                   frame_rise;
   logic                   sync_rise;
   logic [SAMPLE_W-1:0]    mem_q [FIFO_SLOTS];
   logic [PTR_W-1:0]       wr_ptr_q;
   logic [PTR_W-1:0]       rd_ptr_q;
   logic [PTR_W-1:0]       depth;
   logic                   div_q;
   logic [7:0]             cfg2_q;
   dfs_ctrl_t              ctrl_q;
   dfs_sample_t            out_q;
   logic                   bvalid_q;
   logic [1:0]             bresp_q;
   logic                   rvalid_q;
   logic [1:0]             rresp_q;
   logic [DATA_W-1:0]      rdata_q;
   logic                   aw_take;
   logic                   ar_take;
   dfs_sel_t               wsel;
   dfs_sel_t               rsel;

   // three-stage pin sampling; stage one feeds stage two only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q[0] <= '0;
         meta_q[1] <= '0;
         meta_q[2] <= '0;
      end
      else
      begin
         meta_q[0] <= {sample_data, sync_ref_in, frame_in, dac_sample_clock, source_data_clock};
         meta_q[1] <= meta_q[0];
         meta_q[2] <= meta_q[1];
      end
   end

   // a bit's level is accepted once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++)
      begin : g_lvl
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               lvl_q[gi] <= 1'b0;
            else if (meta_q[1][gi] == meta_q[2][gi])
               lvl_q[gi] <= meta_q[2][gi];
         end
      end
      for (gi = 0; gi < PIN_EDGES; gi++)
      begin : g_rise
         assign rise[gi] = (meta_q[1][gi] == meta_q[2][gi]) & meta_q[2][gi] & ~lvl_q[gi];
      end
   endgenerate

   assign wr_tick    = rise[PIN_SRC_CLK];
   assign dac_tick   = rise[PIN_DAC];
   assign frame_rise = rise[PIN_FRAME];
   assign sync_rise  = rise[PIN_SYNC];

   // in 2x the half-rate phase gates reads; phase alone shifts latency by one dac cycle
   assign rd_tick = dac_tick & (~ctrl_q.interp_2x | div_q);

   // half-rate divider; free phase until the sync reference forces it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_q <= RST_DIV_PHASE;
      else if (sync_rise)
         div_q <= ctrl_q.div_phase;
      else if (dac_tick)
         div_q <= ~div_q;
   end

   // write side: frame returns the write pointer to slot zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wr_ptr_q <= '0;
      else if (frame_rise)
         wr_ptr_q <= '0;
      else if (wr_tick)
         wr_ptr_q <= wr_ptr_q + 3'h1;
   end

   // read side: sync places the read pointer the set depth behind slot zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rd_ptr_q <= '0;
      else if (sync_rise)
         rd_ptr_q <= 3'h0 - ctrl_q.reset_depth;
      else if (rd_tick)
         rd_ptr_q <= rd_ptr_q + 3'h1;
   end

   assign depth = wr_ptr_q - rd_ptr_q;

   // sample store; no reset needed, data path only
   always_ff @(posedge aclk)
   begin
      if (wr_tick)
         mem_q[wr_ptr_q] <= lvl_q[PIN_W-1:PIN_EDGES];
   end

   // word leaves after the read pointer has walked depth slots
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_q <= '0;
      else
      begin
         out_q.valid <= rd_tick & ~sync_rise;
         if (rd_tick & ~sync_rise)
            out_q.data <= mem_q[rd_ptr_q];
      end
   end

   assign filter_out = out_q;

   // bus handshake: address and data taken together, one at a time
   assign s_axi_awready = s_axi_wvalid & ~bvalid_q;
   assign s_axi_wready  = s_axi_awvalid & ~bvalid_q;
   assign aw_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign ar_take       = s_axi_arvalid & ~rvalid_q;
   assign wsel          = dfs_decode(s_axi_awaddr);
   assign rsel          = dfs_decode(s_axi_araddr);

   // software registers; a zero depth write keeps the old depth
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg2_q <= RST_STARTUP_CFG2;
         ctrl_q <= '{div_phase: RST_DIV_PHASE, interp_2x: RST_INTERP_2X,
                     reset_depth: RST_RESET_DEPTH};
      end
      else if (aw_take & s_axi_wstrb[0])
      begin
         if (wsel == SEL_CFG2)
            cfg2_q <= s_axi_wdata[7:0];
         if (wsel == SEL_CTRL)
         begin
            ctrl_q.interp_2x <= s_axi_wdata[CTRL_INTERP_BIT];
            ctrl_q.div_phase <= s_axi_wdata[CTRL_PHASE_BIT];
            if (s_axi_wdata[CTRL_DEPTH_LSB +: PTR_W] != 3'h0)
               ctrl_q.reset_depth <= s_axi_wdata[CTRL_DEPTH_LSB +: PTR_W];
         end
      end
   end

   // write response; status is read only, so a write to it errs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (aw_take)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wsel == SEL_CFG2 || wsel == SEL_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // read response, data captured at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= '0;
      end
      else if (ar_take)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         rdata_q  <= '0;
         unique case (rsel)
            SEL_CFG2: rdata_q[7:0] <= cfg2_q;
            SEL_CTRL:
            begin
               rdata_q[CTRL_DEPTH_LSB +: PTR_W] <= ctrl_q.reset_depth;
               rdata_q[CTRL_INTERP_BIT]         <= ctrl_q.interp_2x;
               rdata_q[CTRL_PHASE_BIT]          <= ctrl_q.div_phase;
            end
            SEL_STAT:
            begin
               rdata_q[STAT_DEPTH_LSB +: PTR_W] <= depth;
               rdata_q[STAT_WR_LSB +: PTR_W]    <= wr_ptr_q;
               rdata_q[STAT_RD_LSB +: PTR_W]    <= rd_ptr_q;
               rdata_q[STAT_DIV_BIT]            <= div_q;
            end
            SEL_NONE: rdata_q <= '0;
         endcase
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp  = rresp_q;
   assign s_axi_rdata  = rdata_q;

   // checks
   ptr_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_tick && !frame_rise && wr_ptr_q == 3'h7 |=> wr_ptr_q == 3'h0)
      else $error("write pointer did not wrap");
   wr_adv_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_tick && !frame_rise |=> wr_ptr_q == $past(wr_ptr_q) + 3'h1)
      else $error("write pointer did not advance");
   rd_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !rd_tick && !sync_rise |=> $stable(rd_ptr_q))
      else $error("read pointer moved without a tick");
   depth_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sync_rise && !wr_tick && (frame_rise || wr_ptr_q == 3'h0)
      |=> depth == $past(ctrl_q.reset_depth))
      else $error("depth not set by sync reference");
   depth_nonzero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_q.reset_depth != 3'h0)
      else $error("reset depth became zero");
   frame_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      frame_rise |=> wr_ptr_q == 3'h0)
      else $error("frame did not reset write side");
   div_force_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sync_rise |=> div_q == $past(ctrl_q.div_phase))
      else $error("divider not forced by sync");
   half_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_q.interp_2x && dac_tick && !sync_rise
      |-> (rd_tick == div_q) ##1 (div_q != $past(div_q)))
      else $error("read tick off the half-rate phase");
   out_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_tick && !sync_rise |=> filter_out.valid ##1 !filter_out.valid)
      else $error("filter sample not a single pulse");
   bresp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      aw_take |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response missing");

   cov_read_c:  cover property (@(posedge aclk) disable iff (!aresetn) filter_out.valid);
   cov_wrap_c:  cover property (@(posedge aclk) disable iff (!aresetn)
      wr_tick && wr_ptr_q == 3'h7);
   cov_sync_c:  cover property (@(posedge aclk) disable iff (!aresetn) sync_rise ##[1:50] rd_tick);
   cov_err_c:   cover property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule

// ===== dfs_pkg.sv
package dfs_pkg;

   // fifo geometry
   localparam int          FIFO_SLOTS     = 8;
   localparam int          PTR_W          = 3;
   localparam int          SAMPLE_W       = 16;
   localparam int          SYNC_STAGES    = 3;

   // clock on aclk
   localparam int          ACLK_PERIOD_NS = 50;

   // bus geometry
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 32;

   // register indices, byte address is four times the index
   localparam logic [9:0]  IDX_STARTUP_CFG2 = 10'h00E1;
   localparam logic [9:0]  IDX_FIFO_CTRL    = 10'h0001;
   localparam logic [9:0]  IDX_FIFO_STATUS  = 10'h0002;

   // reset values
   localparam logic [7:0]  RST_STARTUP_CFG2 = 8'h00;
   localparam logic [2:0]  RST_RESET_DEPTH  = 3'h4;
   localparam logic        RST_INTERP_2X    = 1'b1;
   localparam logic        RST_DIV_PHASE    = 1'b0;

   // control field positions
   localparam int          CTRL_DEPTH_LSB   = 0;
   localparam int          CTRL_INTERP_BIT  = 4;
   localparam int          CTRL_PHASE_BIT   = 5;

   // status field positions
   localparam int          STAT_DEPTH_LSB   = 0;
   localparam int          STAT_WR_LSB      = 4;
   localparam int          STAT_RD_LSB      = 8;
   localparam int          STAT_DIV_BIT     = 12;

   // axi responses
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // synchronised pin indices
   localparam int          PIN_SRC_CLK      = 0;
   localparam int          PIN_DAC          = 1;
   localparam int          PIN_FRAME        = 2;
   localparam int          PIN_SYNC         = 3;
   localparam int          PIN_EDGES        = 4;
   localparam int          PIN_W            = PIN_EDGES + SAMPLE_W;

   typedef enum logic [1:0] {SEL_NONE, SEL_CFG2, SEL_CTRL, SEL_STAT} dfs_sel_t;

   typedef struct packed {
      logic                div_phase;
      logic                interp_2x;
      logic [PTR_W-1:0]    reset_depth;
   } dfs_ctrl_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] data;
      logic                valid;
   } dfs_sample_t;

endpackage

// ===== dfs_source_model.sv
`timescale 1ns/1ps
// far-side data source: word set up 4 aclk before its clock rise, held well past the fall
module dfs_source_model
   import dfs_pkg::*;
(
   input  wire logic                aclk,  // bench clock
   input  wire logic                send,  // start one word
   input  wire logic [SAMPLE_W-1:0] word,  // word to send
   output logic                     dclk,  // data clock drive
   output logic [SAMPLE_W-1:0]      data,  // sample pins drive
   output logic                     busy   // word in flight
);
   // clock stands low between words; stale data is inverted so it cannot pass as valid
   initial
   begin
      dclk = 1'b0;
      data = 16'h5a5a;
      busy = 1'b0;
      forever
      begin
         @(posedge aclk);
         if (send)
         begin
            busy <= 1'b1;
            data <= word;
            repeat (4) @(posedge aclk);
            dclk <= 1'b1;
            repeat (4) @(posedge aclk);
            dclk <= 1'b0;
            repeat (4) @(posedge aclk);
            data <= ~data;
            busy <= 1'b0;
         end
      end
   end
endmodule
